// [logic/bcid_regs.sv]
`timescale 1ns/10ps
// Overview of operation
// - both words read-only, privileged only; unprivileged access returns nothing
// - word one [31:12] holds default high TCM base; [11:2] reserved
// - word one bit 1 is 1 when double precision absent, 0 otherwise or float_unit_absent
// - word one bit 0 is 1 when peripheral ports carry bus protection
// - word two bit 31: 0 single CPU, 1 twin CPU
// - word two bit 30 is 1 when lock-step checking logic is included
// - word two bits 29 and 28 are 1 when instruction or data cache absent
// - word two [27:26] first TCM error scheme: 00 none, 10 32-bit, 11 64-bit
// - word two [25:24] second TCM error scheme, same codes
// - word two bit 23 is 1 when big-endian instruction support is absent
// - word two bit 22 is 1 when no floating-point unit exists
// - word two [21:20] protection unit: 00 absent, 10 twelve, 11 sixteen regions
// - [19:17] breakpoints minus one, [16:14] watchpoints minus one
// - bits 13, 12, 11 are 1 when first TCM, bank-0, bank-1 ports absent
// - word two bit 10 is 1 when TCM address parity logic is built in
// - word two bit 9 is 1 when the AXI slave port is absent
// - [8:7] instruction cache scheme 00/01/11, forced 00 without instruction cache
// - [6:5] data cache scheme 00/01/10, forced 00 without data cache
// - word two bit 4 is 1 when corrected-error store is absent
// - word two bit 3 is 1 when AXI bus protection logic is included
// - word two bit 2 is 1 when split/lock logic is built in
// - bit 1 AHB peripheral ports present, bit 0 coherency port present
module bcid_regs
    import bcid_pkg::*;
#(
    // build options, word one
    parameter logic [19:0] TIGHTLY_COUPLED_MEM_HIGH_DEFAULT = 20'h00000,
    parameter bit          DOUBLE_PRECISION_ABSENT          = 1'b0,
    parameter bit          PERIPH_PORT_BUS_PROTECTION       = 1'b0,
    // build options, word two
    parameter bit          TWIN_CPU                         = 1'b0,
    parameter bit          LOCK_STEP_PRESENT                = 1'b0,
    parameter bit          INSTR_CACHE_ABSENT               = 1'b0,
    parameter bit          DATA_CACHE_ABSENT                = 1'b0,
    parameter logic [1:0]  FIRST_TCM_ERROR_SCHEME           = 2'h0,
    parameter logic [1:0]  SECOND_TCM_ERROR_SCHEME          = 2'h0,
    parameter bit          BIG_ENDIAN_INSTR_ABSENT          = 1'b0,
    parameter bit          FLOAT_UNIT_ABSENT                = 1'b0,
    parameter logic [1:0]  PROTECTION_REGION_COUNT          = 2'h3,
    parameter int          BREAKPOINT_COUNT                 = 8,
    parameter int          WATCHPOINT_COUNT                 = 8,
    parameter bit          FIRST_TCM_PORT_ABSENT            = 1'b0,
    parameter bit          SECOND_TCM_BANK0_ABSENT          = 1'b0,
    parameter bit          SECOND_TCM_BANK1_ABSENT          = 1'b0,
    parameter bit          TCM_ADDRESS_CHECK_PRESENT        = 1'b0,
    parameter bit          AXI_SLAVE_ABSENT                 = 1'b0,
    parameter logic [1:0]  INSTR_CACHE_PROTECTION           = 2'h0,
    parameter logic [1:0]  DATA_CACHE_PROTECTION            = 2'h0,
    parameter bit          CORRECTED_ERROR_STORE_ABSENT     = 1'b0,
    parameter bit          AXI_BUS_PROTECTION               = 1'b0,
    parameter bit          SPLIT_LOCK_FLAG                  = 1'b0,
    parameter bit          AHB_PERIPH_PORT_PRESENT          = 1'b0,
    parameter bit          COHERENCY_PORT_FLAG              = 1'b0
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // coprocessor request
    input  wire logic        cp_valid,
    input  wire logic        cp_read,
    input  wire logic        cp_priv,
    input  wire logic [2:0]  cp_opc1,
    input  wire logic [3:0]  cp_crn,
    input  wire logic [3:0]  cp_crm,
    input  wire logic [2:0]  cp_opc2,
    // coprocessor answer
    output logic             cp_done,
    output logic             cp_undef,
    output logic [31:0]      cp_rdata
);
    bcid_sel_if sel ();

    // counts are stored minus one in three bits
    localparam logic [2:0] BREAK_FIELD = 3'(BREAKPOINT_COUNT - 1);
    localparam logic [2:0] WATCH_FIELD = 3'(WATCHPOINT_COUNT - 1);

    wire logic [31:0] value_one;
    wire logic [31:0] value_two;
    wire logic [31:0] word_one;
    wire logic [31:0] word_two;
    wire logic        double_field;
    wire logic [1:0]  icache_field;
    wire logic [1:0]  dcache_field;
    wire logic        any_hit;
    wire logic        granted;
    wire logic [31:0] next_rdata;

    // request decode
    bcid_cp_decode u_decode (
        .cp_valid (cp_valid),
        .cp_read  (cp_read),
        .cp_priv  (cp_priv),
        .cp_opc1  (cp_opc1),
        .cp_crn   (cp_crn),
        .cp_crm   (cp_crm),
        .cp_opc2  (cp_opc2),
        .sel      (sel.decoder)
    );

    // derived fields; a missing unit forces its dependent scheme to none
    assign double_field = DOUBLE_PRECISION_ABSENT && !FLOAT_UNIT_ABSENT;
    assign icache_field = INSTR_CACHE_ABSENT ? ES_NONE : INSTR_CACHE_PROTECTION;
    assign dcache_field = DATA_CACHE_ABSENT ? ES_NONE : DATA_CACHE_PROTECTION;

    // word one: reserved bits 11:2 read zero
    assign value_one = {TIGHTLY_COUPLED_MEM_HIGH_DEFAULT, 10'h000,
                        double_field,
                        PERIPH_PORT_BUS_PROTECTION};

    // word two, from bit 31 down
    assign value_two = {TWIN_CPU,
                        LOCK_STEP_PRESENT,
                        INSTR_CACHE_ABSENT,
                        DATA_CACHE_ABSENT,
                        FIRST_TCM_ERROR_SCHEME,
                        SECOND_TCM_ERROR_SCHEME,
                        BIG_ENDIAN_INSTR_ABSENT,
                        FLOAT_UNIT_ABSENT,
                        PROTECTION_REGION_COUNT,
                        BREAK_FIELD,
                        WATCH_FIELD,
                        FIRST_TCM_PORT_ABSENT,
                        SECOND_TCM_BANK0_ABSENT,
                        SECOND_TCM_BANK1_ABSENT,
                        TCM_ADDRESS_CHECK_PRESENT,
                        AXI_SLAVE_ABSENT,
                        icache_field,
                        dcache_field,
                        CORRECTED_ERROR_STORE_ABSENT,
                        AXI_BUS_PROTECTION,
                        SPLIT_LOCK_FLAG,
                        AHB_PERIPH_PORT_PRESENT,
                        COHERENCY_PORT_FLAG};

    // held words, loaded once after reset
    bcid_word_store u_store (
        .clock          (clock),
        .rst_b          (rst_b),
        .word_one_value (value_one),
        .word_two_value (value_two),
        .word_one       (word_one),
        .word_two       (word_two)
    );

    // answer selection; refused accesses return zero so no content leaks
    assign any_hit    = sel.hit_one || sel.hit_two;
    assign granted    = any_hit && sel.allowed;
    assign next_rdata = !granted ? RDATA_RESET : (sel.hit_two ? word_two : word_one);

    // one-cycle answer; a write or unprivileged access is flagged undefined
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cp_done  <= 1'b0;
            cp_undef <= 1'b0;
            cp_rdata <= RDATA_RESET;
        end else begin
            cp_done  <= any_hit;
            cp_undef <= any_hit && !sel.allowed;
            cp_rdata <= next_rdata;
        end
    end

    // helper state for the checks below: which word was asked for
    logic asked_two;
    logic settled;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            asked_two <= 1'b0;
            settled   <= 1'b0;
        end else begin
            asked_two <= sel.hit_two;
            settled   <= 1'b1;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // a granted read of word one, answered next cycle
    sequence s_read_one;
        sel.hit_one && sel.allowed && settled;
    endsequence
    sequence s_read_two;
        sel.hit_two && sel.allowed && settled;
    endsequence

    a_refused_no_data: assert property (any_hit && !sel.allowed |=> cp_done && cp_undef && cp_rdata == 32'h0)
        else $error("refused access returned data or was not flagged");
    a_granted_not_undef: assert property (granted |=> cp_done && !cp_undef)
        else $error("granted read flagged undefined");
    a_done_needs_hit: assert property (!any_hit |=> !cp_done && !cp_undef)
        else $error("answer without a matching request");
    a_one_high_base: assert property (s_read_one |=> cp_rdata[31:12] == TIGHTLY_COUPLED_MEM_HIGH_DEFAULT && cp_rdata[11:2] == 10'h000)
        else $error("word one base or reserved field wrong");
    a_one_double_bit: assert property (s_read_one |=> cp_rdata[1] == (DOUBLE_PRECISION_ABSENT && !FLOAT_UNIT_ABSENT))
        else $error("double precision bit wrong");
    a_one_prot_bit: assert property (s_read_one |=> cp_rdata[0] == PERIPH_PORT_BUS_PROTECTION)
        else $error("peripheral protection bit wrong");
    a_two_cpu_lock: assert property (s_read_two |=> cp_rdata[31:30] == {TWIN_CPU, LOCK_STEP_PRESENT})
        else $error("cpu count or lock-step bit wrong");
    a_two_cache_absent: assert property (s_read_two |=> cp_rdata[29:28] == {INSTR_CACHE_ABSENT, DATA_CACHE_ABSENT})
        else $error("cache absent bits wrong");
    a_two_tcm_schemes: assert property (s_read_two |=> cp_rdata[27:24] == {FIRST_TCM_ERROR_SCHEME, SECOND_TCM_ERROR_SCHEME})
        else $error("tcm error schemes wrong");
    a_two_fpu_region: assert property (s_read_two |=> cp_rdata[23:20] == {BIG_ENDIAN_INSTR_ABSENT, FLOAT_UNIT_ABSENT, PROTECTION_REGION_COUNT})
        else $error("endian, fpu or region field wrong");
    a_two_debug_counts: assert property (s_read_two |=> cp_rdata[19:17] == 3'(BREAKPOINT_COUNT - 1) && cp_rdata[16:14] == 3'(WATCHPOINT_COUNT - 1))
        else $error("debug counts not stored minus one");
    a_two_port_bits: assert property (s_read_two |=> cp_rdata[13:9] == {FIRST_TCM_PORT_ABSENT, SECOND_TCM_BANK0_ABSENT, SECOND_TCM_BANK1_ABSENT, TCM_ADDRESS_CHECK_PRESENT, AXI_SLAVE_ABSENT})
        else $error("port presence bits wrong");
    a_cache_scheme_forced: assert property (s_read_two |=> (!INSTR_CACHE_ABSENT || cp_rdata[8:7] == 2'h0) && (!DATA_CACHE_ABSENT || cp_rdata[6:5] == 2'h0))
        else $error("cache scheme not forced to none");
    a_two_low_bits: assert property (s_read_two |=> cp_rdata[4:0] == {CORRECTED_ERROR_STORE_ABSENT, AXI_BUS_PROTECTION, SPLIT_LOCK_FLAG, AHB_PERIPH_PORT_PRESENT, COHERENCY_PORT_FLAG})
        else $error("low option bits wrong");
    a_words_stay_fixed: assert property (settled && $past(settled) |-> $stable(word_one) && $stable(word_two))
        else $error("build word changed after reset");
    a_write_no_effect: assert property (any_hit && !cp_read ##1 (s_read_one or s_read_two) |=> cp_rdata == (asked_two ? value_two : value_one))
        else $error("write disturbed a build word");

endmodule // bcid_regs

// [logic/bcid_pkg.sv]
package bcid_pkg;

    // coprocessor encoding of both build words; they share opc1, crn and crm and differ only in opc2
    localparam logic [2:0] BCID_OPC1     = 3'h0;
    localparam logic [3:0] BCID_CRN      = 4'hf;
    localparam logic [3:0] BCID_CRM      = 4'h2;
    localparam logic [2:0] BCID_OPC2_ONE = 3'h0;
    localparam logic [2:0] BCID_OPC2_TWO = 3'h1;

    // field positions, build_config_one
    localparam int ONE_TCM_HIGH_LSB = 12;
    localparam int ONE_DOUBLE_BIT   = 1;
    localparam int ONE_PROT_BIT     = 0;

    // field positions, build_config_two
    localparam int TWO_CPU_BIT      = 31;
    localparam int TWO_LOCK_BIT     = 30;
    localparam int TWO_NO_ICACHE    = 29;
    localparam int TWO_NO_DCACHE    = 28;
    localparam int TWO_FIRST_ES_LSB = 26;
    localparam int TWO_SECOND_ES_LSB = 24;
    localparam int TWO_BIG_END_BIT  = 23;
    localparam int TWO_FLOAT_UNIT_ABSENT_BIT   = 22;
    localparam int TWO_REGION_LSB   = 20;
    localparam int TWO_BREAK_LSB    = 17;
    localparam int TWO_WATCH_LSB    = 14;
    localparam int TWO_FIRST_TCM    = 13;
    localparam int TWO_BANK0_BIT    = 12;
    localparam int TWO_BANK1_BIT    = 11;
    localparam int TWO_PARITY_BIT   = 10;
    localparam int TWO_NO_SLAVE     = 9;
    localparam int TWO_INSTR_CACHE_PROTECTION_LSB = 7;
    localparam int TWO_DATA_CACHE_PROTECTION_LSB = 5;
    localparam int TWO_NO_STORE_BIT = 4;
    localparam int TWO_AXI_PROT_BIT = 3;
    localparam int TWO_SPLIT_BIT    = 2;
    localparam int TWO_AHB_BIT      = 1;
    localparam int TWO_COHERE_BIT   = 0;

    // error scheme and region encodings
    localparam logic [1:0] ES_NONE        = 2'h0;
    localparam logic [1:0] ES_TCM_32      = 2'h2;
    localparam logic [1:0] ES_TCM_64      = 2'h3;
    localparam logic [1:0] ES_CACHE_PAR   = 2'h1;
    localparam logic [1:0] ES_ICACHE_64   = 2'h3;
    localparam logic [1:0] ES_DCACHE_32   = 2'h2;
    localparam logic [1:0] REGIONS_NONE   = 2'h0;
    localparam logic [1:0] REGIONS_12     = 2'h2;
    localparam logic [1:0] REGIONS_16     = 2'h3;

    // reset values
    localparam logic [31:0] RDATA_RESET   = 32'h0;
    localparam logic [31:0] WORD_RESET    = 32'h0;

endpackage

// [logic/bcid_sel_if.sv]
`timescale 1ns/10ps
// decoded access, from the decoder to the register bank
interface bcid_sel_if;
    logic hit_one;
    logic hit_two;
    logic allowed;
    modport decoder (output hit_one, output hit_two, output allowed);
    modport bank    (input hit_one, input hit_two, input allowed);
endinterface

// [logic/bcid_cp_decode.sv]
`timescale 1ns/10ps
module bcid_cp_decode
    import bcid_pkg::*;
(
    // coprocessor request
    input  wire logic       cp_valid,
    input  wire logic       cp_read,
    input  wire logic       cp_priv,
    input  wire logic [2:0] cp_opc1,
    input  wire logic [3:0] cp_crn,
    input  wire logic [3:0] cp_crm,
    input  wire logic [2:0] cp_opc2,
    // decoded result
    bcid_sel_if.decoder     sel
);
    wire logic space_hit;

    // only privileged reads may see the words; writes are never allowed
    assign space_hit   = cp_valid && (cp_opc1 == BCID_OPC1) && (cp_crn == BCID_CRN) && (cp_crm == BCID_CRM);
    assign sel.hit_one = space_hit && (cp_opc2 == BCID_OPC2_ONE);
    assign sel.hit_two = space_hit && (cp_opc2 == BCID_OPC2_TWO);
    assign sel.allowed = cp_read && cp_priv;
endmodule // bcid_cp_decode

// [logic/bcid_word_store.sv]
`timescale 1ns/10ps
module bcid_word_store
    import bcid_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // build-time values
    input  wire logic [31:0] word_one_value,
    input  wire logic [31:0] word_two_value,
    // held words
    output logic      [31:0] word_one,
    output logic      [31:0] word_two
);
    logic loaded;

    // words load once, on the first edge after reset; nothing writes them later
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            loaded   <= 1'b0;
            word_one <= WORD_RESET;
            word_two <= WORD_RESET;
        end else if (!loaded) begin
            loaded   <= 1'b1;
            word_one <= word_one_value;
            word_two <= word_two_value;
        end
    end
endmodule // bcid_word_store

// [verification/bcid_regs_tb_top.sv]
`timescale 1ns/10ps
module bcid_regs_tb_top;
    import bcid_pkg::*;
    // build values chosen so that most fields differ from their defaults
    localparam logic [19:0] TCM_HIGH = 20'hab5c3;
    localparam bit          OPT_YES   = 1'b1; // a build option switched on
    localparam int          BREAKS_A  = 6;
    localparam int          WATCHES_A = 3;
    // second build: the smallest and largest counts that fit the three-bit fields
    localparam int          BREAKS_B  = 1;
    localparam int          WATCHES_B = 8;
    localparam logic [31:0] EXP_ONE  = {TCM_HIGH, 10'h0, 1'b1, 1'b1};
    // data cache scheme asked as 32-bit but the cache is absent, so it must read zero
    localparam logic [31:0] EXP_TWO  = {4'h9, ES_TCM_32, ES_TCM_64, 2'h2, REGIONS_12, 3'h5, 3'h2,
                                        4'hb, 1'b0, ES_CACHE_PAR, ES_NONE, 5'h15};
    // design ports
    logic        clock;
    logic        rst_b;
    logic        cp_valid;
    logic        cp_read;
    logic        cp_priv;
    logic [2:0]  cp_opc1;
    logic [3:0]  cp_crn;
    logic [3:0]  cp_crm;
    logic [2:0]  cp_opc2;
    logic        cp_done;
    logic        cp_undef;
    logic [31:0] cp_rdata;
    logic [31:0] alt_rdata;
    // model and bookkeeping
    logic        exp_done;
    logic        exp_undef;
    logic [31:0] exp_rdata;
    logic [31:0] word;
    logic [31:0] alt_word;
    logic        got_done;
    logic        got_undef;
    logic        hit;
    logic        refuse;
    logic        checking;
    int          bad_count;
    int          cmp_count;
    int          seed;

    bcid_regs #(.TIGHTLY_COUPLED_MEM_HIGH_DEFAULT(TCM_HIGH), .DOUBLE_PRECISION_ABSENT(OPT_YES),
        .PERIPH_PORT_BUS_PROTECTION(OPT_YES), .TWIN_CPU(OPT_YES), .DATA_CACHE_ABSENT(OPT_YES),
        .FIRST_TCM_ERROR_SCHEME(ES_TCM_32), .SECOND_TCM_ERROR_SCHEME(ES_TCM_64),
        .BIG_ENDIAN_INSTR_ABSENT(OPT_YES), .PROTECTION_REGION_COUNT(REGIONS_12), .BREAKPOINT_COUNT(BREAKS_A),
        .WATCHPOINT_COUNT(WATCHES_A), .FIRST_TCM_PORT_ABSENT(OPT_YES), .SECOND_TCM_BANK1_ABSENT(OPT_YES),
        .TCM_ADDRESS_CHECK_PRESENT(OPT_YES), .INSTR_CACHE_PROTECTION(ES_CACHE_PAR),
        .DATA_CACHE_PROTECTION(ES_DCACHE_32), .CORRECTED_ERROR_STORE_ABSENT(OPT_YES),
        .SPLIT_LOCK_FLAG(OPT_YES), .COHERENCY_PORT_FLAG(OPT_YES)) i_bcid_regs (
        .clock(clock), .rst_b(rst_b), .cp_valid(cp_valid), .cp_read(cp_read), .cp_priv(cp_priv),
        .cp_opc1(cp_opc1), .cp_crn(cp_crn), .cp_crm(cp_crm), .cp_opc2(cp_opc2),
        .cp_done(cp_done), .cp_undef(cp_undef), .cp_rdata(cp_rdata));

    // second build: no float unit and no instruction cache, to see forced fields
    bcid_regs #(.DOUBLE_PRECISION_ABSENT(OPT_YES), .FLOAT_UNIT_ABSENT(OPT_YES), .INSTR_CACHE_ABSENT(OPT_YES),
        .INSTR_CACHE_PROTECTION(ES_ICACHE_64), .PROTECTION_REGION_COUNT(REGIONS_NONE),
        .BREAKPOINT_COUNT(BREAKS_B), .WATCHPOINT_COUNT(WATCHES_B)) i_bcid_regs_b (
        .clock(clock), .rst_b(rst_b), .cp_valid(cp_valid), .cp_read(cp_read), .cp_priv(cp_priv),
        .cp_opc1(cp_opc1), .cp_crn(cp_crn), .cp_crm(cp_crm), .cp_opc2(cp_opc2),
        .cp_done(), .cp_undef(), .cp_rdata(alt_rdata));

    // 50 ns clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // one access; the answer is captured in the cycle after the taking edge
    task automatic access(input logic rd, input logic pr, input logic [3:0] cn, input logic [2:0] o2);
        @(posedge clock);
        cp_valid <= 1'b1;
        cp_read  <= rd;
        cp_priv  <= pr;
        cp_crn   <= cn;
        cp_opc2  <= o2;
        @(posedge clock);
        cp_valid <= 1'b0;
        @(negedge clock);
        word      = cp_rdata;
        alt_word  = alt_rdata;
        got_done  = cp_done;
        got_undef = cp_undef;
    endtask

    // reference model: inputs seen at the edge give the answer one cycle later
    always @(posedge clock) begin
        hit    = cp_valid && cp_opc1 == BCID_OPC1 && cp_crn == BCID_CRN && cp_crm == BCID_CRM && cp_opc2 < 3'h2;
        refuse = !cp_read || !cp_priv;
        exp_done  <= rst_b && hit;
        exp_undef <= rst_b && hit && refuse;
        exp_rdata <= (rst_b && hit && !refuse) ? (cp_opc2[0] ? EXP_TWO : EXP_ONE) : 32'h0;
    end

    // every cycle the outputs must match the model
    always @(negedge clock) begin
        if (checking) begin
            check({cp_undef, cp_done}, {exp_undef, exp_done});
            check(cp_rdata, exp_rdata);
        end
    end

    // hang guard
    initial begin
        repeat (5000) @(posedge clock);
        bad_count++;
        stop_test();
    end

    initial begin
        seed = 81685;
        bad_count = 0;
        cmp_count = 0;
        checking = 1'b0;
        rst_b <= 1'b0;
        cp_valid <= 1'b0;
        cp_read <= 1'b1;
        cp_priv <= 1'b1;
        cp_opc1 <= BCID_OPC1;
        cp_crn <= BCID_CRN;
        cp_crm <= BCID_CRM;
        cp_opc2 <= BCID_OPC2_ONE;
        @(posedge clock);
        checking = 1'b1;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        // word one fields, both builds
        access(1'b1, 1'b1, BCID_CRN, BCID_OPC2_ONE);
        check(32'(word[31:12]), 32'(TCM_HIGH));
        check(32'(word[11:2]), 32'h0);
        check(32'(word[1:0]), 32'h3);
        check(32'(alt_word[1]), 32'h0);
        $display("test word_one done");
        // word two fields, field by field
        access(1'b1, 1'b1, BCID_CRN, BCID_OPC2_TWO);
        check(32'(word[31:28]), 32'h9);
        check(32'(word[27:24]), {28'h0, ES_TCM_32, ES_TCM_64});
        check(32'(word[23:20]), {28'h0, 2'h2, REGIONS_12});
        check(32'(word[19:14]), 32'h2a);
        check(32'(word[13:9]), 32'h16);
        check(32'(word[8:5]), {28'h0, ES_CACHE_PAR, ES_NONE});
        check(32'(word[4:0]), 32'h15);
        check(32'(alt_word[31:28]), 32'h2);
        check(32'(alt_word[22:14]), 32'h107);
        check(32'(alt_word[8:7]), 32'h0);
        $display("test word_two done");
        // unprivileged read and privileged write are refused
        access(1'b1, 1'b0, BCID_CRN, BCID_OPC2_TWO);
        check({30'h0, got_undef, got_done}, 32'h3);
        check(word, 32'h0);
        access(1'b0, 1'b1, BCID_CRN, BCID_OPC2_ONE);
        check({30'h0, got_undef, got_done}, 32'h3);
        access(1'b1, 1'b1, BCID_CRN, BCID_OPC2_ONE);
        check(word, EXP_ONE);
        // a foreign register number draws no answer
        access(1'b1, 1'b1, 4'he, BCID_OPC2_ONE);
        check(32'(got_done), 32'h0);
        $display("test refusals done");
        // back-to-back random traffic, model checks every cycle
        repeat (80) begin
            @(posedge clock);
            cp_valid <= 1'($random(seed));
            cp_read  <= ($random(seed) & 3) != 0;
            cp_priv  <= ($random(seed) & 3) != 0;
            cp_opc1  <= (($random(seed) & 7) == 0) ? 3'h1 : BCID_OPC1;
            cp_crn   <= (($random(seed) & 7) == 0) ? 4'h5 : BCID_CRN;
            cp_crm   <= (($random(seed) & 7) == 0) ? 4'h3 : BCID_CRM;
            cp_opc2  <= 3'($random(seed) % 3);
        end
        @(posedge clock);
        cp_valid <= 1'b0;
        cp_opc1 <= BCID_OPC1;
        cp_crm <= BCID_CRM;
        $display("test random done");
        // reset in mid-run, words clear and reload with the same contents
        rst_b <= 1'b0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        access(1'b1, 1'b1, BCID_CRN, BCID_OPC2_TWO);
        check(word, EXP_TWO);
        $display("test second_reset done");
        repeat (2) @(posedge clock);
        stop_test();
    end
endmodule // bcid_regs_tb_top
